// file: include/dcac_pkg.sv
package dcac_pkg;

    typedef logic [31:0] dcac_word_t;
    typedef logic [2:0]  dcac_width_t;
    typedef logic [11:0] dcac_count_t;

    // Register indices on the bus (word address bits 4:2).
    localparam logic [2:0] DCAC_IDX_SRC  = 3'h0;
    localparam logic [2:0] DCAC_IDX_DST  = 3'h1;
    localparam logic [2:0] DCAC_IDX_NEXT = 3'h2;
    localparam logic [2:0] DCAC_IDX_CTRL = 3'h3;
    localparam logic [2:0] DCAC_IDX_CFG  = 3'h4;

    // Control word field positions.
    localparam int DCAC_CTRL_DST_INC = 27;
    localparam int DCAC_CTRL_SRC_INC = 26;
    localparam int DCAC_CTRL_DW_HI   = 23;
    localparam int DCAC_CTRL_DW_LO   = 21;
    localparam int DCAC_CTRL_SW_HI   = 20;
    localparam int DCAC_CTRL_SW_LO   = 18;
    localparam int DCAC_CTRL_CNT_HI  = 11;
    localparam int DCAC_CTRL_CNT_LO  = 0;
    localparam int DCAC_CFG_ENABLE   = 0;
    localparam int DCAC_NEXT_LO      = 2;

    localparam dcac_word_t DCAC_WORD_RESET = 32'h0000_0000;
    localparam dcac_word_t DCAC_CTRL_MASK  = 32'h0CFC_0FFF;
    localparam dcac_word_t DCAC_NEXT_MASK  = 32'hFFFF_FFFC;
    localparam dcac_count_t DCAC_COUNT_ZERO = 12'h000;
    localparam dcac_count_t DCAC_COUNT_ONE  = 12'h001;

    // Width codes.
    localparam dcac_width_t DCAC_W_BYTE = 3'h0;
    localparam dcac_width_t DCAC_W_HALF = 3'h1;
    localparam dcac_width_t DCAC_W_WORD = 3'h2;

    typedef enum logic [1:0] {
        DCAC_IDLE = 2'b00,
        DCAC_RUN  = 2'b01,
        DCAC_LINK = 2'b10
    } dcac_state_t;

    // Byte count of one beat for a width code; reserved codes step by one.
    function automatic dcac_word_t dcac_width_bytes(input dcac_width_t w);
        case (w)
            DCAC_W_HALF: dcac_width_bytes = 32'h0000_0002;
            DCAC_W_WORD: dcac_width_bytes = 32'h0000_0004;
            default:     dcac_width_bytes = 32'h0000_0001;
        endcase
    endfunction

endpackage

// file: design/dcac_addr_step.sv
`timescale 1ns/1ps
module dcac_addr_step
    import dcac_pkg::*;
(
    input  wire dcac_pkg::dcac_word_t  addr_i,
    input  wire logic                  incr_i,
    input  wire dcac_pkg::dcac_width_t width_i,
    output logic [31:0]                next_o
);
    // Next address after one beat: advance by the beat's byte count or hold.
    always_comb
    begin
        next_o = incr_i ? addr_i + dcac_width_bytes(width_i) : addr_i;
    end
endmodule

// file: design/dcac_channel.sv
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// (R1) Source address register, 32-bit, resets zero.
// (R2) Software aligns source to source width.
// (R3) Enable takes up programmed register contents.
// (R4) Source address advances while transferring.
// (R5) Software disables before rewriting source.
// (R6) Destination address register, 32-bit, resets zero.
// (R7) Software aligns destination to destination width.
// (R8) Software disables before rewriting destination.
// (R9) Next pointer bits 31:2; low bits zero.
// (R10) Software keeps pointer below top limit.
// (R11) Zero pointer ends chain, clears enable.
// (R12) Control bits choose increment or fixed addresses.
// (R13) Increment by width byte count per beat.
module dcac_channel
    import dcac_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [4:2]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire dcac_pkg::dcac_word_t wb_dat_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic                 beat_i,
    input  wire logic                 link_ack_i,
    output logic [31:0]               source_address_o,
    output logic [31:0]               destination_address_o,
    output logic                      active_o,
    output logic                      done_o,
    output logic                      link_req_o,
    output logic [31:0]               link_addr_o
);
    dcac_word_t  src, next_src, dst, next_dst, nxt, next_nxt;
    dcac_word_t  ctrl, next_ctrl, act_ctrl, next_act_ctrl;
    dcac_word_t  act_nxt, next_act_nxt, rdata, next_rdata;
    dcac_word_t  src_step, dst_step, wmask;
    dcac_count_t remain, next_remain;
    dcac_state_t state, next_state;
    logic        ack, next_ack, done, next_done;
    logic        next_active, next_link_req;
    logic        wr, rd, cfg_on, cfg_off, beat_ok;

    // Bus write happens only at the edge where ack is high; read data is taken up while ack is low.
    assign wr      = wb_cyc_i & wb_stb_i & ack & wb_we_i;
    assign rd      = wb_cyc_i & wb_stb_i & ~wb_we_i;
    assign cfg_on  = wr & (wb_adr_i == DCAC_IDX_CFG) & wb_sel_i[0]
                     & wb_dat_i[DCAC_CFG_ENABLE];
    assign cfg_off = wr & (wb_adr_i == DCAC_IDX_CFG) & wb_sel_i[0]
                     & ~wb_dat_i[DCAC_CFG_ENABLE];
    assign beat_ok = (state == DCAC_RUN) & beat_i
                     & (remain != DCAC_COUNT_ZERO);

    // Byte lanes selected by sel.
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_lane
            assign wmask[8*g +: 8] = {8{wb_sel_i[g]}};
        end
    endgenerate

    // Address steppers for source and destination, using taken-up controls.
    dcac_addr_step u_src_step (
        .addr_i  (src),
        .incr_i  (act_ctrl[DCAC_CTRL_SRC_INC]),
        .width_i (act_ctrl[DCAC_CTRL_SW_HI:DCAC_CTRL_SW_LO]),
        .next_o  (src_step)
    );
    dcac_addr_step u_dst_step (
        .addr_i  (dst),
        .incr_i  (act_ctrl[DCAC_CTRL_DST_INC]),
        .width_i (act_ctrl[DCAC_CTRL_DW_HI:DCAC_CTRL_DW_LO]),
        .next_o  (dst_step)
    );

    // Bus answer: one wait cycle, registered ack and read data.
    always_comb
    begin
        next_ack   = wb_cyc_i & wb_stb_i & ~ack;
        next_rdata = DCAC_WORD_RESET;
        if (rd & ~ack)
        begin
            case (wb_adr_i)
                DCAC_IDX_SRC:  next_rdata = src;
                DCAC_IDX_DST:  next_rdata = dst;
                DCAC_IDX_NEXT: next_rdata = nxt & DCAC_NEXT_MASK; // R9
                DCAC_IDX_CTRL: next_rdata = ctrl;
                DCAC_IDX_CFG:  next_rdata[DCAC_CFG_ENABLE] =
                                   (state != DCAC_IDLE);
                default:       next_rdata = DCAC_WORD_RESET;
            endcase
        end
    end

    // Programmed registers, hardware address stepping and channel sequence.
    always_comb
    begin
        next_src      = src;
        next_dst      = dst;
        next_nxt      = nxt;
        next_ctrl     = ctrl;
        next_act_ctrl = act_ctrl;
        next_act_nxt  = act_nxt;
        next_remain   = remain;
        next_state    = state;
        next_done     = 1'b0;
        // Software writes to the address group are honoured while stopped
        // or while a link is pending, so a running channel keeps its group.
        if (wr & ((state == DCAC_IDLE) | (state == DCAC_LINK)))
        begin
            case (wb_adr_i)
                DCAC_IDX_SRC:  next_src = (src & ~wmask) | (wb_dat_i & wmask);
                DCAC_IDX_DST:  next_dst = (dst & ~wmask) | (wb_dat_i & wmask);
                DCAC_IDX_NEXT: next_nxt = ((nxt & ~wmask) | (wb_dat_i & wmask))
                                          & DCAC_NEXT_MASK; // R9
                DCAC_IDX_CTRL: next_ctrl = ((ctrl & ~wmask)
                                            | (wb_dat_i & wmask))
                                           & DCAC_CTRL_MASK;
                default:       next_ctrl = ctrl;
            endcase
        end
        case (state)
            DCAC_IDLE:
            begin
                if (cfg_on)
                begin
                    next_state    = DCAC_RUN; // R3
                    next_act_ctrl = ctrl;
                    next_act_nxt  = nxt;
                    next_remain   = ctrl[DCAC_CTRL_CNT_HI:DCAC_CTRL_CNT_LO];
                end
            end
            DCAC_RUN:
            begin
                if (cfg_off)
                    next_state = DCAC_IDLE;
                else if (remain == DCAC_COUNT_ZERO)
                begin
                    next_done  = 1'b1;
                    // A zero pointer marks the last item and stops the channel.
                    next_state = (act_nxt == DCAC_WORD_RESET) ? DCAC_IDLE
                                                              : DCAC_LINK; // R11
                end
                else if (beat_ok)
                begin
                    next_src    = src_step; // R4 R12 R13
                    next_dst    = dst_step; // R12 R13
                    next_remain = remain - DCAC_COUNT_ONE;
                end
            end
            DCAC_LINK:
            begin
                if (cfg_off)
                    next_state = DCAC_IDLE;
                else if (link_ack_i)
                begin
                    next_state    = DCAC_RUN; // R3
                    next_act_ctrl = ctrl;
                    next_act_nxt  = nxt;
                    next_remain   = ctrl[DCAC_CTRL_CNT_HI:DCAC_CTRL_CNT_LO];
                end
            end
            default:
                next_state = DCAC_IDLE;
        endcase
        // Output levels follow the state that is about to be entered.
        next_active   = (next_state == DCAC_RUN);
        next_link_req = (next_state == DCAC_LINK);
    end

    // State registers; all outputs are taken straight from flip-flops.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            src        <= DCAC_WORD_RESET; // R1
            dst        <= DCAC_WORD_RESET; // R6
            nxt        <= DCAC_WORD_RESET;
            ctrl       <= DCAC_WORD_RESET;
            act_ctrl   <= DCAC_WORD_RESET;
            act_nxt    <= DCAC_WORD_RESET;
            rdata      <= DCAC_WORD_RESET;
            remain     <= DCAC_COUNT_ZERO;
            state      <= DCAC_IDLE;
            ack        <= 1'b0;
            done       <= 1'b0;
            active_o   <= 1'b0;
            link_req_o <= 1'b0;
        end
        else
        begin
            src        <= next_src;
            dst        <= next_dst;
            nxt        <= next_nxt;
            ctrl       <= next_ctrl;
            act_ctrl   <= next_act_ctrl;
            act_nxt    <= next_act_nxt;
            rdata      <= next_rdata;
            remain     <= next_remain;
            state      <= next_state;
            ack        <= next_ack;
            done       <= next_done;
            active_o   <= next_active;
            link_req_o <= next_link_req;
        end
    end

    assign wb_ack_o              = ack;
    assign wb_dat_o              = rdata;
    assign done_o                = done;
    assign source_address_o      = src;
    assign destination_address_o = dst;
    assign link_addr_o           = act_nxt;

    // Checks of the address group behaviour.
    AST_SRC_RESET: assert property (@(posedge clk_i) // R1
        rst_i |=> (source_address_o == DCAC_WORD_RESET))
        else $error("source address not zero after reset");
    AST_DST_RESET: assert property (@(posedge clk_i) // R6
        rst_i |=> (destination_address_o == DCAC_WORD_RESET) && !active_o)
        else $error("destination address not zero after reset");
    AST_TAKE_UP: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        (state == DCAC_IDLE) && cfg_on |=> active_o
        && (remain == $past(ctrl[DCAC_CTRL_CNT_HI:DCAC_CTRL_CNT_LO]))
        && (act_ctrl == $past(ctrl)))
        else $error("enable did not take up the programmed contents");
    AST_SRC_STEP: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        beat_ok && !cfg_off && act_ctrl[DCAC_CTRL_SRC_INC] |=>
        source_address_o == $past(src) + dcac_width_bytes(
            $past(act_ctrl[DCAC_CTRL_SW_HI:DCAC_CTRL_SW_LO])))
        else $error("source address did not advance by its width");
    AST_DST_STEP: assert property (@(posedge clk_i) disable iff (rst_i) // R13
        beat_ok && !cfg_off && act_ctrl[DCAC_CTRL_DST_INC] |=>
        destination_address_o == $past(dst) + dcac_width_bytes(
            $past(act_ctrl[DCAC_CTRL_DW_HI:DCAC_CTRL_DW_LO])))
        else $error("destination address did not advance by its width");
    AST_FIXED: assert property (@(posedge clk_i) disable iff (rst_i) // R12
        beat_ok && !act_ctrl[DCAC_CTRL_SRC_INC] |=> $stable(source_address_o))
        else $error("fixed source address moved");
    AST_NEXT_LOW: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        rd && !ack && (wb_adr_i == DCAC_IDX_NEXT) |=>
        wb_ack_o && (wb_dat_o[1:0] == 2'b00) && (wb_dat_o == $past(nxt)))
        else $error("next pointer read back wrong");
    AST_CHAIN_END: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        (state == DCAC_RUN) && (remain == DCAC_COUNT_ZERO)
        && (act_nxt == DCAC_WORD_RESET) && !cfg_off |=> done_o && !active_o
        && !link_req_o && (state == DCAC_IDLE))
        else $error("last chain item did not stop the channel");
endmodule

// file: testbench/dcac_master_model.sv
`timescale 1ns/1ps
// Stands in for the bus master: it moves beats while the channel runs and
// confirms a descriptor load once the bench has programmed the registers.
module dcac_master_model
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic active_i,
    input  wire logic link_req_i,
    input  wire logic slow_i,
    input  wire logic desc_ready_i,
    output logic      beat_o,
    output logic      link_ack_o
);
    logic next_beat;
    logic next_link_ack;

    // A slow master moves a beat only on every other cycle.
    always_comb
    begin
        next_beat     = active_i & ~(slow_i & beat_o);
        next_link_ack = link_req_i & desc_ready_i & ~link_ack_o;
    end

    // Registers the master's strobes on the channel's clock.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            beat_o     <= 1'b0;
            link_ack_o <= 1'b0;
        end
        else
        begin
            beat_o     <= next_beat;
            link_ack_o <= next_link_ack;
        end
    end
endmodule

// file: testbench/dcac_channel_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
    $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module dcac_channel_tb;
    import dcac_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic        slow  = 1'b0;
    logic        ready = 1'b0;
    logic [2:0]  adr   = 3'h0;
    logic [3:0]  sel   = 4'h0;
    logic [3:0]  lanes = 4'hF;
    dcac_word_t  wdat  = 32'h0000_0000;
    dcac_word_t  rdat;
    logic [31:0] dat_o, src_o, dst_o, link_o;
    logic        ack, active, done, link_req, beat, link_ack;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          cycles = 0;

    // The clock toggles every half period of 12.5 ns.
    always #12.5 clk_i = ~clk_i;

    dcac_channel dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .beat_i(beat),
        .link_ack_i(link_ack), .source_address_o(src_o),
        .destination_address_o(dst_o), .active_o(active), .done_o(done),
        .link_req_o(link_req), .link_addr_o(link_o));

    dcac_master_model master (.clk_i(clk_i), .rst_i(rst_i),
        .active_i(active), .link_req_i(link_req), .slow_i(slow),
        .desc_ready_i(ready), .beat_o(beat), .link_ack_o(link_ack));

    // Prints the verdict and ends the run.
    task finish_test;
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Cuts a hang short well beyond the length of all scenarios.
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            $display("mismatch at %0t: timeout", $time);
            finish_test();
        end
    end

    // One classic cycle: hold the request until ack is sampled high.
    task wb(input logic w, input logic [2:0] i, input dcac_word_t d);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= i;
        wdat <= d;
        sel  <= lanes;
        do @(posedge clk_i); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    // Builds a control word from its fields.
    function automatic dcac_word_t mk_ctrl(input logic di, input logic si,
        input dcac_width_t dw, input dcac_width_t sw, input dcac_count_t n);
        dcac_word_t c;
        c = 32'h0000_0000;
        c[DCAC_CTRL_DST_INC] = di;
        c[DCAC_CTRL_SRC_INC] = si;
        c[DCAC_CTRL_DW_HI:DCAC_CTRL_DW_LO] = dw;
        c[DCAC_CTRL_SW_HI:DCAC_CTRL_SW_LO] = sw;
        c[DCAC_CTRL_CNT_HI:DCAC_CTRL_CNT_LO] = n;
        return c;
    endfunction

    // Programs an idle channel and then enables it.
    task run(input dcac_word_t s, input dcac_word_t d, input dcac_word_t c,
        input dcac_word_t nx);
        wb(1'b1, DCAC_IDX_SRC, s);
        wb(1'b1, DCAC_IDX_DST, d);
        wb(1'b1, DCAC_IDX_NEXT, nx);
        wb(1'b1, DCAC_IDX_CTRL, c);
        wb(1'b1, DCAC_IDX_CFG, 32'h0000_0001);
    endtask

    // Waits for the end-of-transfer pulse and checks that it lasts one cycle.
    task wait_done;
        do @(posedge clk_i); while (done !== 1'b1);
        @(posedge clk_i);
        `CHK(done, 1'b0)
    endtask

    // Reset values, including an unmapped index that reads zero.
    task t_reset;
        wb(1'b0, DCAC_IDX_SRC, 32'h0000_0000);
        `CHK(rdat, DCAC_WORD_RESET)
        wb(1'b0, DCAC_IDX_DST, 32'h0000_0000);
        `CHK(rdat, DCAC_WORD_RESET)
        wb(1'b0, DCAC_IDX_NEXT, 32'h0000_0000);
        `CHK(rdat, DCAC_WORD_RESET)
        wb(1'b1, 3'h5, 32'hFFFF_FFFF);
        wb(1'b0, 3'h5, 32'h0000_0000);
        `CHK(rdat, DCAC_WORD_RESET)
    endtask

    // Address registers read back written patterns; a write with sel 4'h3 changes only the low two byte lanes.
    task t_regs;
        wb(1'b1, DCAC_IDX_SRC, 32'hA5C3_0F96);
        wb(1'b0, DCAC_IDX_SRC, 32'h0000_0000);
        `CHK(rdat, 32'hA5C3_0F96)
        lanes = 4'h3;
        wb(1'b1, DCAC_IDX_SRC, 32'h1234_5678);
        lanes = 4'hF;
        wb(1'b0, DCAC_IDX_SRC, 32'h0000_0000);
        `CHK(rdat, 32'hA5C3_5678)
        wb(1'b1, DCAC_IDX_DST, 32'h5A3C_F069);
        wb(1'b0, DCAC_IDX_DST, 32'h0000_0000);
        `CHK(rdat, 32'h5A3C_F069)
        wb(1'b1, DCAC_IDX_NEXT, 32'hFFFF_FFEC);
        wb(1'b0, DCAC_IDX_NEXT, 32'h0000_0000);
        `CHK(rdat, 32'hFFFF_FFEC)
    endtask

    // Word source and half-word destination both step; a zero pointer stops.
    task t_incr;
        run(32'h0000_1000, 32'h0000_2002,
            mk_ctrl(1'b1, 1'b1, DCAC_W_HALF, DCAC_W_WORD, 12'h003),
            32'h0000_0000);
        wait_done();
        `CHK(src_o, 32'h0000_100C)
        `CHK(dst_o, 32'h0000_2008)
        `CHK(active, 1'b0)
        `CHK(link_req, 1'b0)
        wb(1'b0, DCAC_IDX_CFG, 32'h0000_0000);
        `CHK(rdat[DCAC_CFG_ENABLE], 1'b0)
    endtask

    // Fixed source, stepping byte destination, with a stalling master.
    task t_fixed;
        slow <= 1'b1;
        run(32'h0000_3003, 32'h0000_4001,
            mk_ctrl(1'b1, 1'b0, DCAC_W_BYTE, DCAC_W_BYTE, 12'h004),
            32'h0000_0000);
        wait_done();
        `CHK(src_o, 32'h0000_3003)
        `CHK(dst_o, 32'h0000_4005)
        slow <= 1'b0;
    endtask

    // A nonzero pointer requests the next item, which then ends the chain.
    task t_chain;
        run(32'h0000_0100, 32'h0000_0200,
            mk_ctrl(1'b1, 1'b1, DCAC_W_WORD, DCAC_W_WORD, 12'h002),
            32'h0000_8000);
        do @(posedge clk_i); while (link_req !== 1'b1);
        `CHK(link_o, 32'h0000_8000)
        `CHK(src_o, 32'h0000_0108)
        wb(1'b1, DCAC_IDX_SRC, 32'h0000_0500);
        wb(1'b1, DCAC_IDX_CTRL,
            mk_ctrl(1'b0, 1'b1, DCAC_W_WORD, DCAC_W_WORD, 12'h001));
        wb(1'b1, DCAC_IDX_NEXT, 32'h0000_0000);
        ready <= 1'b1;
        wait_done();
        ready <= 1'b0;
        `CHK(src_o, 32'h0000_0504)
        `CHK(dst_o, 32'h0000_0208)
        `CHK(active, 1'b0)
    endtask

    // Holds reset for 16 cycles, then runs every scenario.
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_regs();
        t_incr();
        t_fixed();
        t_chain();
        finish_test();
    end
endmodule
